/* core/pdl_core.sv */
// duty loop, saturation feedforward, sync/interleave and monitor core
// Operation
// [R01] duty never exceeds the programmed duty limit
// [R02] software sets limit a little above vout over minimum vin
// [R03] feedforward forces duty to zero or limit by error sign
// [R04] inside the window duty follows the compensation filter
// [R05] an excursion reaches the limit within one switching cycle
// [R06] feedforward enable bit sits beside the limit; off means no jumps
// [R07] software caps the limit near 120-140 percent when feedforward used
// [R08] software leaves feedforward off above 2.0 V output
// [R09] filter is third order, three zeros and three poles
// [R10] filter uses four numerator and three denominator coefficients
// [R11] numerator coefficients are high/low pairs, denominators single
// [R12] vout, iout and temperature digitised at 8 bits
// [R13] each quantity sampled at least at 700 Hz
// [R14] latest results kept in three freely refreshed registers
// [R15] current reading corrected using temperature reading
// [R16] manager copies monitor registers into its ring buffer
// [R17] switching cycle locked to master clock at 500k, 750k, 1M
// [R18] pwm edge lags master clock edge in 11.25 degree steps
// [R19] new settings take effect only at a switching-cycle boundary
`timescale 1ns/1ps
`default_nettype none
module pdl_core
	import pdl_pkg::*;
#(
	parameter int               MON_STEP = MON_STEP_DEF,
	parameter logic signed [7:0] SAT_WIN = 8'sh10
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        we_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	input  wire logic        sync_data_line_i,
	input  wire logic signed [7:0] err_i,
	output logic             pwm_o,
	output logic             adc_start_o,
	output logic [1:0]       adc_ch_o,
	input  wire logic        adc_done_i,
	input  wire logic [7:0]  adc_data_i
);
	if (MON_STEP < 4 || MON_STEP > MON_STEP_DEF || MON_STEP >= (1 << 17)) begin : g_chk
		$error("pdl_core: MON_STEP out of range");
	end
	if (SAT_WIN < 8'sh01) begin : g_chk_win
		$error("pdl_core: SAT_WIN must be positive");
	end

	// ****************************************
	// register file
	// ****************************************
	logic [8:0]        duty_limit_reg;
	logic [4:0]        phase_reg;
	logic [1:0]        freq_reg;
	logic [7:0]        num_coef_reg [0:7];
	logic [7:0]        den_coef1;
	logic [7:0]        den_coef2;
	logic [7:0]        den_coef3;
	logic [7:0]        vout_monitor_reg;
	logic [7:0]        iout_monitor_reg;
	logic [7:0]        temp_monitor_reg;
	logic              ack_reg;
	logic [31:0]       rdata_reg;
	logic              wr_go;
	logic [31:0]       rd_next;
	logic              sat_hi_reg;
	logic              sat_lo_reg;
	logic              lock_reg;
	logic [7:0]        duty_reg;

	// write lands on the edge where the master sees ack
	assign wr_go = cyc_i && stb_i && we_i && ack_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= cyc_i && stb_i && !ack_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			duty_limit_reg <= {1'b0, DL_LIMIT_RST};
			phase_reg      <= '0;
			freq_reg       <= FSW_500K;
			num_coef_reg   <= '{default: 8'h00};
			den_coef1      <= '0;
			den_coef2      <= '0;
			den_coef3      <= '0;
		end else if (wr_go) begin
			unique case (adr_i)
				ADR_DUTY_LIMIT: begin
					if (sel_i[0]) duty_limit_reg[7:0] <= dat_i[7:0]; // R01
					if (sel_i[1]) duty_limit_reg[DL_SAT_BIT] <= dat_i[DL_SAT_BIT]; // R06
				end
				ADR_PHASE: if (sel_i[0]) phase_reg <= dat_i[4:0];
				ADR_FREQ:  if (sel_i[0]) freq_reg <= dat_i[1:0];
				ADR_DEN1:  if (sel_i[0]) den_coef1 <= dat_i[7:0]; // R11
				ADR_DEN2:  if (sel_i[0]) den_coef2 <= dat_i[7:0]; // R11
				ADR_DEN3:  if (sel_i[0]) den_coef3 <= dat_i[7:0]; // R11
				default: begin
					for (int i = 0; i < 8; i++) begin
						if (adr_i == ADR_NUM_BASE + 8'(4 * i) && sel_i[0]) begin
							num_coef_reg[i] <= dat_i[7:0]; // R11
						end
					end
				end
			endcase
		end
	end

	always_comb begin
		rd_next = '0;
		unique case (adr_i)
			ADR_DUTY_LIMIT: rd_next[8:0] = duty_limit_reg;
			ADR_PHASE:      rd_next[4:0] = phase_reg;
			ADR_FREQ:       rd_next[1:0] = freq_reg;
			ADR_DEN1:       rd_next[7:0] = den_coef1;
			ADR_DEN2:       rd_next[7:0] = den_coef2;
			ADR_DEN3:       rd_next[7:0] = den_coef3;
			ADR_VOUT_MON:   rd_next[7:0] = vout_monitor_reg; // R14
			ADR_IOUT_MON:   rd_next[7:0] = iout_monitor_reg; // R14
			ADR_TEMP_MON:   rd_next[7:0] = temp_monitor_reg; // R14
			ADR_STATUS: begin
				rd_next[7:0]      = duty_reg;
				rd_next[ST_SAT_HI] = sat_hi_reg;
				rd_next[ST_SAT_LO] = sat_lo_reg;
				rd_next[ST_LOCK]   = lock_reg;
			end
			default: begin
				for (int i = 0; i < 8; i++) begin
					if (adr_i == ADR_NUM_BASE + 8'(4 * i)) rd_next[7:0] = num_coef_reg[i];
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= '0;
		end else if (cyc_i && stb_i && !ack_reg) begin
			rdata_reg <= rd_next;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = rdata_reg;

	// ****************************************
	// master clock sync and interleave
	// ****************************************
	logic       s1_reg;
	logic       s2_reg;
	logic       s3_reg;
	logic       lvl_reg;
	logic       lvl_d_reg;
	logic       sync_rise;
	logic [8:0] period_act;
	logic [4:0] phase_act;
	logic [8:0] pos_reg;
	logic [8:0] ph_cnt_reg;
	logic       ph_arm_reg;
	logic [13:0] dly_prod;
	logic       realign;
	logic       cyc_start;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg    <= 1'b0;
			s2_reg    <= 1'b0;
			s3_reg    <= 1'b0;
			lvl_reg   <= 1'b0;
			lvl_d_reg <= 1'b0;
		end else begin
			s1_reg    <= sync_data_line_i;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			// a change counts only once two stages agree
			if (s2_reg == s3_reg) lvl_reg <= s3_reg;
			lvl_d_reg <= lvl_reg;
		end
	end
	assign sync_rise = lvl_reg && !lvl_d_reg;

	// lag = period * steps / 32, one step being 11.25 degrees
	assign dly_prod = period_act * phase_act; // R18
	assign realign  = ph_arm_reg && (ph_cnt_reg == '0);
	assign cyc_start = realign || (pos_reg == period_act - 9'h001); // R17

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_cnt_reg <= '0;
			ph_arm_reg <= 1'b0;
			lock_reg   <= 1'b0;
		end else if (sync_rise) begin
			ph_cnt_reg <= dly_prod[13:PHASE_W]; // R18
			ph_arm_reg <= 1'b1;
		end else if (ph_arm_reg) begin
			if (ph_cnt_reg == '0) begin
				ph_arm_reg <= 1'b0;
				lock_reg   <= 1'b1;
			end else begin
				ph_cnt_reg <= ph_cnt_reg - 9'h001;
			end
		end
	end

	// free-runs between master edges, snapped back on each lagged edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_reg <= '0;
		end else if (cyc_start) begin
			pos_reg <= '0; // R17
		end else begin
			pos_reg <= pos_reg + 9'h001;
		end
	end

	// ****************************************
	// settings shadowed at the cycle boundary
	// ****************************************
	logic [7:0]  lim_act;
	logic        sat_act;
	logic [15:0] c_act [0:3];
	logic [7:0]  b_act [1:3];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lim_act    <= DL_LIMIT_RST;
			sat_act    <= 1'b0;
			period_act <= PER_500K;
			phase_act  <= '0;
			c_act      <= '{NUM_C0_RST, 16'h0000, 16'h0000, 16'h0000};
			b_act      <= '{default: 8'h00};
		end else if (cyc_start) begin
			lim_act   <= duty_limit_reg[7:0]; // R19
			sat_act   <= duty_limit_reg[DL_SAT_BIT]; // R19
			phase_act <= phase_reg;
			for (int i = 0; i < 4; i++) begin
				c_act[i] <= {num_coef_reg[2 * i], num_coef_reg[2 * i + 1]}; // R11 R19
			end
			b_act[1] <= den_coef1;
			b_act[2] <= den_coef2;
			b_act[3] <= den_coef3;
			unique case (freq_reg)
				FSW_500K: period_act <= PER_500K;
				FSW_750K: period_act <= PER_750K;
				FSW_1M:   period_act <= PER_1M;
				default:  period_act <= PER_500K;
			endcase
		end
	end

	// ****************************************
	// compensation and saturation feedforward
	// ****************************************
	logic signed [15:0] filt_y;
	logic [7:0]         filt_duty;
	logic [7:0]         duty_next;
	logic               hi_next;
	logic               lo_next;

	pdl_filter #(
		.E_W (8),
		.C_W (16),
		.B_W (8),
		.Y_W (16)
	) u_filter (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.step_i (cyc_start),
		.err_i  (err_i),
		.c0_i   (c_act[0]),
		.c1_i   (c_act[1]),
		.c2_i   (c_act[2]),
		.c3_i   (c_act[3]),
		.den1_i (b_act[1]),
		.den2_i (b_act[2]),
		.den3_i (b_act[3]),
		.y_o    (filt_y)
	);

	always_comb begin
		if (filt_y < 16'sh0000) begin
			filt_duty = 8'h00;
		end else if (filt_y > 16'(lim_act)) begin
			filt_duty = lim_act; // R01
		end else begin
			filt_duty = filt_y[7:0]; // R04
		end
		hi_next   = sat_act && (err_i > SAT_WIN); // R03 R06
		lo_next   = sat_act && (err_i < -SAT_WIN); // R03 R06
		duty_next = hi_next ? lim_act : (lo_next ? 8'h00 : filt_duty); // R03 R05
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			duty_reg   <= '0;
			sat_hi_reg <= 1'b0;
			sat_lo_reg <= 1'b0;
		end else if (cyc_start) begin
			duty_reg   <= duty_next; // R05
			sat_hi_reg <= hi_next;
			sat_lo_reg <= lo_next;
		end
	end

	// ****************************************
	// pwm generator
	// ****************************************
	logic [16:0] on_prod;
	logic        pwm_reg;

	assign on_prod = duty_reg * period_act;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_reg <= 1'b0;
		end else begin
			pwm_reg <= pos_reg < on_prod[16:DUTY_FRAC]; // R01
		end
	end
	assign pwm_o = pwm_reg;

	// ****************************************
	// monitoring sequencer
	// ****************************************
	logic [16:0]       mon_cnt_reg;
	pdl_chan_type      ch_reg;
	logic              start_reg;
	logic signed [8:0] dt;
	logic signed [17:0] i_prod;
	logic signed [17:0] i_corr;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mon_cnt_reg <= '0;
			start_reg   <= 1'b0;
			ch_reg      <= MON_CH_VOUT;
		end else begin
			start_reg <= 1'b0;
			if (mon_cnt_reg == 17'(MON_STEP - 1)) begin
				mon_cnt_reg <= '0;
				start_reg   <= 1'b1; // R13
				unique case (ch_reg)
					MON_CH_VOUT: ch_reg <= MON_CH_IOUT;
					MON_CH_IOUT: ch_reg <= MON_CH_TEMP;
					MON_CH_TEMP: ch_reg <= MON_CH_VOUT;
					default:     ch_reg <= MON_CH_VOUT;
				endcase
			end else begin
				mon_cnt_reg <= mon_cnt_reg + 17'h00001;
			end
		end
	end
	assign adc_start_o = start_reg;
	assign adc_ch_o    = ch_reg;

	// inductor resistance rises with heat, so scale the reading back
	assign dt     = $signed({1'b0, temp_monitor_reg}) - $signed({1'b0, TEMP_REF});
	assign i_prod = $signed({1'b0, adc_data_i}) * dt;
	assign i_corr = $signed({10'h000, adc_data_i}) - (i_prod >>> TC_SHIFT); // R15

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vout_monitor_reg <= '0;
			iout_monitor_reg <= '0;
			temp_monitor_reg <= TEMP_REF;
		end else if (adc_done_i) begin
			unique case (ch_reg)
				MON_CH_VOUT: vout_monitor_reg <= adc_data_i; // R12 R14
				MON_CH_IOUT: begin
					if (i_corr < 0) iout_monitor_reg <= 8'h00; // R15
					else if (i_corr > 18'sh000ff) iout_monitor_reg <= 8'hff;
					else iout_monitor_reg <= i_corr[7:0]; // R14
				end
				MON_CH_TEMP: temp_monitor_reg <= adc_data_i; // R12 R14
				default: ;
			endcase
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	duty_cap_a: assert property (@(posedge clk_i) disable iff (rst_i) // R01
		cyc_start |=> duty_reg <= $past(lim_act))
		else $error("duty above limit");
	sat_high_a: assert property (@(posedge clk_i) disable iff (rst_i) // R03
		(cyc_start && sat_act && err_i > SAT_WIN) |=> duty_reg == $past(lim_act))
		else $error("high excursion not forced to limit");
	sat_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // R03
		(cyc_start && sat_act && err_i < -SAT_WIN) |=> duty_reg == 8'h00)
		else $error("low excursion not forced to zero");
	sat_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		(cyc_start && !sat_act) |=> !sat_hi_reg && !sat_lo_reg
			&& duty_reg == $past(filt_duty))
		else $error("jump while feedforward off");
	in_window_a: assert property (@(posedge clk_i) disable iff (rst_i) // R04
		(cyc_start && err_i <= SAT_WIN && err_i >= -SAT_WIN) |=> duty_reg == $past(filt_duty))
		else $error("duty not from filter inside window");
	full_on_a: assert property (@(posedge clk_i) disable iff (rst_i) // R05
		(cyc_start && hi_next && lim_act >= 8'h10)
			|=> ##1 pwm_o [*8])
		else $error("pwm not driven to limit in cycle");
	shadow_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		!$past(cyc_start) |-> $stable(lim_act) && $stable(sat_act) && $stable(period_act))
		else $error("setting changed mid period");
	// spacing far exceeds any delay range, so count it in a helper register
	logic [16:0] mon_gap_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i || start_reg) begin
			mon_gap_reg <= '0;
		end else begin
			mon_gap_reg <= mon_gap_reg + 17'h00001;
		end
	end

	mon_rate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		(start_reg |=> !start_reg) and (mon_gap_reg <= 17'(MON_STEP)))
		else $error("monitor conversion late");
	mon_store_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
		(adc_done_i && ch_reg == MON_CH_VOUT) |=> vout_monitor_reg == $past(adc_data_i))
		else $error("vout result not stored");
	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
		else $error("ack not one cycle");
endmodule
`default_nettype wire

/* core/pdl_pkg.sv */
// constants and types shared by the duty loop and monitor core
package pdl_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_HZ      = 200_000_000;
	localparam int FSW_500K_HZ = 500_000;
	localparam int FSW_750K_HZ = 750_000;
	localparam int FSW_1M_HZ   = 1_000_000;
	localparam int MON_RATE_HZ = 700;
	localparam int MON_CHANS   = 3;
	// longest allowed spacing between two conversions, rounded down
	localparam int MON_STEP_DEF = CLK_HZ / (MON_RATE_HZ * MON_CHANS);
	localparam logic [8:0] PER_500K = 9'(CLK_HZ / FSW_500K_HZ);
	localparam logic [8:0] PER_750K = 9'(CLK_HZ / FSW_750K_HZ);
	localparam logic [8:0] PER_1M   = 9'(CLK_HZ / FSW_1M_HZ);
	localparam int PHASE_W   = 5;
	localparam int DUTY_FRAC = 8;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] ADR_DUTY_LIMIT = 8'h00;
	localparam logic [7:0] ADR_PHASE      = 8'h04;
	localparam logic [7:0] ADR_FREQ       = 8'h08;
	localparam logic [7:0] ADR_NUM_BASE   = 8'h0c;
	localparam logic [7:0] ADR_DEN1       = 8'h2c;
	localparam logic [7:0] ADR_DEN2       = 8'h30;
	localparam logic [7:0] ADR_DEN3       = 8'h34;
	localparam logic [7:0] ADR_VOUT_MON   = 8'h38;
	localparam logic [7:0] ADR_IOUT_MON   = 8'h3c;
	localparam logic [7:0] ADR_TEMP_MON   = 8'h40;
	localparam logic [7:0] ADR_STATUS     = 8'h44;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int         DL_SAT_BIT   = 8;
	localparam logic [7:0] DL_LIMIT_RST = 8'hc0;
	localparam logic [15:0] NUM_C0_RST  = 16'h0100;
	localparam logic [7:0] TEMP_REF     = 8'h19;
	localparam int         TC_SHIFT     = 8;
	localparam int         NUM_SHIFT    = 8;
	localparam int         DEN_SHIFT    = 6;
	localparam int         ST_SAT_HI    = 8;
	localparam int         ST_SAT_LO    = 9;
	localparam int         ST_LOCK      = 10;

	typedef enum logic [1:0] {
		FSW_500K = 2'b00,
		FSW_750K = 2'b01,
		FSW_1M   = 2'b10
	} pdl_fsw_type;

	typedef enum logic [1:0] {
		MON_CH_VOUT = 2'b00,
		MON_CH_IOUT = 2'b01,
		MON_CH_TEMP = 2'b10
	} pdl_chan_type;
endpackage

/* core/pdl_filter.sv */
// third-order compensation filter, steps once per switching cycle
`timescale 1ns/1ps
`default_nettype none
module pdl_filter
	import pdl_pkg::*;
#(
	parameter int E_W = 8,
	parameter int C_W = 16,
	parameter int B_W = 8,
	parameter int Y_W = 16
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  step_i,
	input  wire logic signed [E_W-1:0] err_i,
	input  wire logic signed [C_W-1:0] c0_i,
	input  wire logic signed [C_W-1:0] c1_i,
	input  wire logic signed [C_W-1:0] c2_i,
	input  wire logic signed [C_W-1:0] c3_i,
	input  wire logic signed [B_W-1:0] den1_i,
	input  wire logic signed [B_W-1:0] den2_i,
	input  wire logic signed [B_W-1:0] den3_i,
	output logic signed [Y_W-1:0]      y_o
);
	if (E_W + C_W > 30 || B_W + Y_W > 30) begin : g_chk
		$error("pdl_filter: widths too large for accumulator");
	end

	logic signed [E_W-1:0] e_reg [1:3];
	logic signed [Y_W-1:0] y_reg [1:3];
	logic signed [31:0]    num_sum;
	logic signed [31:0]    den_sum;
	logic signed [31:0]    acc;
	logic signed [Y_W-1:0] y_next;

	// ****************************************
	// difference equation
	// ****************************************
	// four zero taps and three pole taps; den1 near unity gives the integrator
	always_comb begin
		num_sum = 32'(c0_i * err_i) + 32'(c1_i * e_reg[1])
			+ 32'(c2_i * e_reg[2]) + 32'(c3_i * e_reg[3]); // R09 R10
		den_sum = 32'(den1_i * y_reg[1]) + 32'(den2_i * y_reg[2])
			+ 32'(den3_i * y_reg[3]); // R09 R10
		acc = (num_sum >>> NUM_SHIFT) + (den_sum >>> DEN_SHIFT);
		// saturate so a large excursion cannot wrap the integrator
		if (acc > 32'sd32767) begin
			y_next = Y_W'(16'sh7fff);
		end else if (acc < -32'sd32768) begin
			y_next = Y_W'(16'sh8000);
		end else begin
			y_next = Y_W'(acc);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			e_reg <= '{default: '0};
			y_reg <= '{default: '0};
		end else if (step_i) begin
			e_reg[1] <= err_i;
			e_reg[2] <= e_reg[1];
			e_reg[3] <= e_reg[2];
			y_reg[1] <= y_next;
			y_reg[2] <= y_reg[1];
			y_reg[3] <= y_reg[2];
		end
	end

	assign y_o = y_reg[1];
endmodule
`default_nettype wire

/* bench/pdl_far_model.sv */
// converter front end and manager sync model facing the duty loop core
`timescale 1ns/1ps
`default_nettype none
module pdl_far_model (
	input  wire logic        clk_i,
	input  wire logic        adc_start_i,
	input  wire logic [1:0]  adc_ch_i,
	input  wire logic        slow_i,
	input  wire logic        sync_go_i,
	output logic             adc_done_o,
	output logic [7:0]       adc_data_o,
	output logic             sync_o,
	output logic [15:0]      max_gap_o
);
	// ****************************************
	// conversions and master clock
	// ****************************************
	int         wait_cnt = 0;
	int         sync_cnt = 0;
	logic [1:0] ch       = 2'h0;
	logic       seen     = 1'b0;
	logic [15:0] gap     = 16'h0000;
	initial begin
		adc_done_o = 1'b0;
		adc_data_o = 8'h00;
		sync_o     = 1'b0;
		max_gap_o  = 16'h0000;
	end
	always @(posedge clk_i) begin
		adc_done_o <= 1'b0;
		// no result on the bus: keep it changing so nothing stale looks valid
		adc_data_o <= ~adc_data_o;
		gap        <= adc_start_i ? 16'h0000 : gap + 16'h0001;
		if (adc_start_i) begin
			seen     <= 1'b1;
			ch       <= adc_ch_i;
			wait_cnt <= slow_i ? 30 : 2;
			if (seen && gap > max_gap_o) max_gap_o <= gap;
		end else if (wait_cnt == 1) begin
			adc_done_o <= 1'b1;
			adc_data_o <= (ch == 2'h0) ? 8'h55 : (ch == 2'h1) ? 8'h80 : 8'h39;
		end
		if (!adc_start_i && wait_cnt > 0) wait_cnt <= wait_cnt - 1;
		// sync line rests low between master clock slopes
		if (sync_go_i) begin
			sync_o   <= 1'b1;
			sync_cnt <= 8;
		end else if (sync_cnt > 1) begin
			sync_cnt <= sync_cnt - 1;
		end else begin
			sync_o   <= 1'b0;
			sync_cnt <= 0;
		end
	end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the duty loop and monitor core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pdl_pkg::*;
	localparam int MON = 40;
	logic              clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic              slow = 1'b0, sync_go = 1'b0, ack, pwm, start, done, sync;
	logic [7:0]        adr = 8'h00, adc_d;
	logic [31:0]       wdat = 32'h0, rd_bus, rd;
	logic [3:0]        sel = 4'h0;
	logic signed [7:0] err = 8'sh00;
	logic [1:0]        ch;
	logic [15:0]       max_gap;
	int                err_count = 0, checked = 0;
	always #2.5 clk = ~clk;
	pdl_core #(.MON_STEP(MON)) dut_u (.clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat),
		.sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(rd_bus), .ack_o(ack),
		.sync_data_line_i(sync), .err_i(err), .pwm_o(pwm), .adc_start_o(start),
		.adc_ch_o(ch), .adc_done_i(done), .adc_data_i(adc_d));
	pdl_far_model far_u (.clk_i(clk), .adc_start_i(start), .adc_ch_i(ch), .slow_i(slow),
		.sync_go_i(sync_go), .adc_done_o(done), .adc_data_o(adc_d), .sync_o(sync),
		.max_gap_o(max_gap));
	// ****************************************
	// shared tasks
	// ****************************************
	task wrap_up;
		if (err_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			$display("unexpected %0t %s got %h want %h", $time, m, got, exp);
			err_count++;
		end
	endtask
	task stop_hang(input string m);
		$display("unexpected %0t wait ran out: %s", $time, m);
		err_count++;
		wrap_up();
	endtask
	// acknowledge comes one edge after the request is taken
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf; n = 0;
		do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) stop_hang("bus ack");
		rd = rd_bus;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk);
	endtask
	task wait_pwm(input logic lvl, output int n);
		n = 0;
		while (pwm !== lvl && n < 1000) begin @(posedge clk); n++; end
		if (pwm !== lvl) stop_hang("pwm level");
	endtask
	function automatic logic [7:0] iout_fix(int raw, int t);
		int c;
		c = raw - ((raw * (t - int'(TEMP_REF))) >>> 8);
		return (c < 0) ? 8'h00 : (c > 255) ? 8'hff : 8'(c);
	endfunction
	// ****************************************
	// scenarios
	// ****************************************
	task t_reset;
		wb(1'b0, ADR_DUTY_LIMIT, 32'h0);
		chk(rd, {24'h0, DL_LIMIT_RST}, "limit reset");
		wb(1'b0, ADR_TEMP_MON, 32'h0);
		chk(rd, {24'h0, TEMP_REF}, "temp reset");
		wb(1'b1, 8'h80, 32'hffff_ffff);
		wb(1'b0, 8'h80, 32'h0);
		chk(rd, 32'h0, "unmapped");
	endtask
	task t_sat;
		int n;
		err <= 8'sh00;
		wb(1'b1, ADR_DUTY_LIMIT, 32'h0000_0140);
		repeat (900) @(posedge clk);
		err <= 8'sh14;
		repeat (3) @(posedge clk);
		wait_pwm(1'b0, n);
		wait_pwm(1'b1, n);
		wait_pwm(1'b0, n);
		chk(32'(n), 32'd100, "forced high width");
		wb(1'b0, ADR_STATUS, 32'h0);
		chk(32'(rd[9:0]), 32'h140, "sat high status");
		err <= 8'hec;
		repeat (403) @(posedge clk);
		n = 0;
		repeat (400) begin @(posedge clk); n += int'(pwm); end
		chk(32'(n), 32'h0, "forced zero");
		wb(1'b0, ADR_STATUS, 32'h0);
		chk(32'(rd[9:0]), 32'h200, "sat low status");
		err <= 8'sh05;
		repeat (803) @(posedge clk);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk(32'(rd[9:8]), 32'h0, "inside window");
		chk(32'(rd[7:0]), 32'h0, "window duty");
		// feedforward off: the integrator alone must run into the clamp
		wb(1'b1, ADR_DUTY_LIMIT, 32'h0000_0040);
		wb(1'b1, ADR_NUM_BASE, 32'h0000_0001);
		wb(1'b1, ADR_DEN1, 32'h0000_0040);
		err <= 8'sh7f;
		repeat (2000) @(posedge clk);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk(32'(rd[9:8]), 32'h0, "no forcing");
		chk(32'(rd[7:0]), 32'h40, "clamped");
	endtask
	task t_freq;
		int per [4] = '{400, 266, 200, 400};
		int a, b;
		wb(1'b1, ADR_DUTY_LIMIT, 32'h0000_0140);
		err <= 8'sh14;
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, ADR_FREQ, 32'(i));
			// skip one pulse: it may still belong to the old period
			wait_pwm(1'b0, a);
			wait_pwm(1'b1, a);
			wait_pwm(1'b0, a);
			wait_pwm(1'b1, a);
			wait_pwm(1'b0, a);
			wait_pwm(1'b1, b);
			chk(32'(a + b), 32'(per[i]), "period");
			chk(32'(a), 32'(per[i] * 64 / 256), "width");
		end
	endtask
	task t_phase;
		int d [2];
		int n;
		for (int k = 0; k < 2; k++) begin
			wb(1'b1, ADR_PHASE, 32'(k * 8));
			wait_pwm(1'b1, n);
			wait_pwm(1'b0, n);
			wait_pwm(1'b1, n);
			wait_pwm(1'b0, n);
			sync_go <= 1'b1;
			@(posedge clk);
			sync_go <= 1'b0;
			wait_pwm(1'b1, d[k]);
		end
		chk(32'(d[1] - d[0]), 32'd100, "lag of eight steps");
		wb(1'b0, ADR_STATUS, 32'h0);
		chk(32'(rd[10]), 32'h1, "locked");
	endtask
	task t_mon;
		slow <= 1'b1;
		repeat (600) @(posedge clk);
		wb(1'b0, ADR_VOUT_MON, 32'h0);
		chk(rd, 32'h55, "vout");
		wb(1'b0, ADR_IOUT_MON, 32'h0);
		chk(rd, {24'h0, iout_fix(128, 57)}, "iout");
		wb(1'b0, ADR_TEMP_MON, 32'h0);
		chk(rd, 32'h39, "temp");
		chk(32'(max_gap < 16'(MON)), 32'h1, "start spacing");
	endtask
	task t_coef;
		logic [7:0] a;
		for (int i = 0; i < 11; i++) begin
			a = ADR_NUM_BASE + 8'(4 * i);
			wb(1'b1, a, 32'(i + 1));
			wb(1'b0, a, 32'h0);
			chk(rd, 32'(i + 1), "coefficient");
		end
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_sat();
		t_freq();
		t_phase();
		t_mon();
		t_coef();
		wrap_up();
	end
endmodule
`default_nettype wire
